// >>> testbench/mbrs_handler_props.sv
// Concurrent checks on the ports of the slave query handler.
`timescale 1ns/100ps
module mbrs_handler_props #(
    parameter integer P_EXT_CYC = 20000
) (
    input wire i_sys_clk,
    input wire i_rstn,
    input wire i_ce,
    input wire i_rx_valid,
    input wire [7:0] i_rx_data,
    input wire i_rx_err,
    input wire [4:0] i_slave_addr,
    input wire i_diag_fault,
    input wire i_gap_mode2,
    input wire [15:0] i_bit_div,
    input wire o_tx_valid,
    input wire [7:0] o_tx_data,
    input wire i_tx_ready,
    input wire [15:0] o_reg_addr,
    input wire [15:0] o_reg_wdata,
    input wire o_reg_wr,
    input wire [15:0] i_reg_rdata,
    input wire i_reg_writable,
    input wire i_reg_in_range
);
    //************
    // Helper logic
    //************
    // Cycles since the last character; saturates so it never wraps.
    logic [15:0] since_rx_ff;
    always @(posedge i_sys_clk) begin
        if (!i_rstn || (i_ce && i_rx_valid))
            since_rx_ff <= 16'h0000;
        else if (i_ce && since_rx_ff != 16'hffff)
            since_rx_ff <= since_rx_ff + 16'h0001;
    end
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rstn);
    //************
    // Properties
    //************
    sequence s_offer;
        o_tx_valid && !i_tx_ready;
    endsequence
    sequence s_write;
        o_reg_wr;
    endsequence
    property p_tx_hold;
        s_offer |=> o_tx_valid && $stable(o_tx_data);
    endproperty
    property p_wr_ok;
        s_write |-> i_reg_writable && i_reg_in_range;
    endproperty
    property p_wr_top;
        s_write |-> o_reg_addr <= 16'h1fff;
    endproperty
    property p_wr_pulse;
        s_write |=> !o_reg_wr && !o_tx_valid;
    endproperty
    property p_tx_nowr;
        o_tx_valid |-> !o_reg_wr;
    endproperty
    property p_wr_gap;
        s_write |-> 32'(since_rx_ff) >= 32'(i_bit_div) * 24
            + (i_gap_mode2 ? P_EXT_CYC : 0);
    endproperty
    property p_addr_silent;
        (i_slave_addr == 5'h00) [*3] |-> !o_tx_valid;
    endproperty
    property p_fault_nowr;
        i_diag_fault [*4] |-> !o_reg_wr;
    endproperty
    a_tx_hold: assert property (p_tx_hold)
        else $error("reply byte changed before it was taken");
    a_wr_ok: assert property (p_wr_ok)
        else $error("write to a refused register");
    a_wr_top: assert property (p_wr_top)
        else $error("write above the register space");
    a_wr_pulse: assert property (p_wr_pulse)
        else $error("write strobe longer than one cycle");
    a_tx_nowr: assert property (p_tx_nowr)
        else $error("write while a reply byte is offered");
    a_wr_gap: assert property (p_wr_gap)
        else $error("write before the frame gap ended");
    a_addr_silent: assert property (p_addr_silent)
        else $error("reply with no address accepted");
    a_fault_nowr: assert property (p_fault_nowr)
        else $error("write while a fault is reported");
endmodule

bind mbrs_handler mbrs_handler_props #(.P_EXT_CYC(P_EXT_CYC)) u_props (.*);

// >>> testbench/mbrs_master_model.sv
// Serial-line master model: sends queries with check code, gathers replies.
`timescale 1ns/100ps
module mbrs_master_model (
    input wire i_clk,
    output logic o_rx_valid,
    output logic [7:0] o_rx_data,
    output logic o_rx_err,
    input wire i_tx_valid,
    input wire [7:0] i_tx_data,
    output logic o_tx_ready
);
    //************
    // Query sender
    //************
    logic [7:0] q[$];
    logic [7:0] rsp[$];
    bit slow = 0;
    initial begin
        o_rx_valid = 1'b0;
        o_rx_data = 8'h00;
        o_rx_err = 1'b0;
        o_tx_ready = 1'b1;
    end
    function automatic logic [15:0] crc16(input logic [7:0] b[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (b[i]) begin
            c = c ^ {8'h00, b[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
        end
        return c;
    endfunction
    task automatic send(input int gap, input int err_at, input bit bad);
        logic [15:0] c;
        c = crc16(q) ^ {15'h0000, bad};
        q.push_back(c[7:0]);
        q.push_back(c[15:8]);
        rsp.delete();
        foreach (q[i]) begin
            @(posedge i_clk);
            #1;
            o_rx_valid = 1'b1;
            o_rx_data = q[i];
            o_rx_err = (i == err_at);
            @(posedge i_clk);
            #1;
            o_rx_valid = 1'b0;
            // A stale byte must not look valid once the strobe is gone.
            o_rx_data = ~q[i];
            o_rx_err = 1'b0;
            repeat (gap) @(posedge i_clk);
        end
    endtask
    //************
    // Reply collector
    //************
    always @(posedge i_clk) begin
        if (i_tx_valid && o_tx_ready)
            rsp.push_back(i_tx_data);
        o_tx_ready <= #1 slow ? ~o_tx_ready : 1'b1;
    end
endmodule

// >>> testbench/test_mbrs_handler.sv
// Self-checking bench for the serial-line slave query handler.
`timescale 1ns/100ps
module test_mbrs_handler;
    localparam int GAP = 24 * 4;
    logic clk, rstn, fault, mode2;
    logic [4:0] sadr;
    wire rxv, rxe, txv, rdy, wr;
    wire [7:0] rxd, txd;
    wire [15:0] radr, wdat;
    int err_count = 0;
    int n_tests = 0;
    int w_cnt = 0;
    logic [15:0] w_adr, w_dat;
    logic [7:0] e[$];
    //************
    // Design, master and register map
    //************
    mbrs_handler #(.P_EXT_CYC(20)) u_dut (
        .i_sys_clk(clk), .i_rstn(rstn), .i_ce(1'b1),
        .i_rx_valid(rxv), .i_rx_data(rxd), .i_rx_err(rxe),
        .i_slave_addr(sadr), .i_diag_fault(fault), .i_gap_mode2(mode2),
        .i_bit_div(16'h0004), .o_tx_valid(txv), .o_tx_data(txd),
        .i_tx_ready(rdy), .o_reg_addr(radr), .o_reg_wdata(wdat),
        .o_reg_wr(wr), .i_reg_rdata(radr ^ 16'h5a5a),
        .i_reg_writable(radr != 16'h0005),
        .i_reg_in_range(wdat < 16'h1000)
    );
    mbrs_master_model u_m (
        .i_clk(clk), .o_rx_valid(rxv), .o_rx_data(rxd), .o_rx_err(rxe),
        .i_tx_valid(txv), .i_tx_data(txd), .o_tx_ready(rdy)
    );
    always @(posedge clk) begin
        if (wr === 1'b1) begin
            w_cnt++;
            w_adr = radr;
            w_dat = wdat;
        end
    end
    //************
    // Shared tasks
    //************
    task automatic chk(input string nm, input logic [15:0] s, x);
        n_tests++;
        if (s !== x) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, x, s);
        end
    endtask
    task automatic expect_rsp;
        logic [15:0] c;
        int k;
        c = u_m.crc16(e);
        e.push_back(c[7:0]);
        e.push_back(c[15:8]);
        k = 0;
        while (u_m.rsp.size() < e.size() && k < 3000) begin
            @(posedge clk);
            k++;
        end
        repeat (20) @(posedge clk);
        chk("rsp_len", 16'(u_m.rsp.size()), 16'(e.size()));
        foreach (e[i]) chk("rsp_byte", {8'h00, u_m.rsp[i]}, {8'h00, e[i]});
    endtask
    task automatic expect_none;
        repeat (GAP + 300) @(posedge clk);
        chk("silent", 16'(u_m.rsp.size()), 16'h0000);
    endtask
    task automatic ld_read;
        u_m.q = '{8'h01, 8'h03, 8'h00, 8'h10, 8'h00, 8'h02};
        e = '{8'h01, 8'h03, 8'h04, 8'h5a, 8'h4a, 8'h5a, 8'h4b};
    endtask
    //************
    // Scenarios
    //************
    task automatic t_read;
        ld_read();
        u_m.send(8, -1, 0);
        expect_rsp();
    endtask
    task automatic t_echo;
        u_m.q = '{8'h01, 8'h06, 8'h00, 8'h20, 8'h01, 8'h23};
        e = u_m.q;
        u_m.send(8, -1, 0);
        expect_rsp();
        chk("wr_addr", w_adr, 16'h0020);
        chk("wr_data", w_dat, 16'h0123);
        // Stalling ready checks that a slow taker loses no byte.
        u_m.slow = 1;
        u_m.q = '{8'h01, 8'h08, 8'h00, 8'h00, 8'h1f, 8'h34};
        e = u_m.q;
        u_m.send(8, -1, 0);
        expect_rsp();
        u_m.slow = 0;
    endtask
    task automatic t_multi;
        w_cnt = 0;
        u_m.q = '{8'h01, 8'h10, 8'h00, 8'h30, 8'h00, 8'h02, 8'h04,
                  8'h00, 8'h11, 8'h00, 8'h22};
        u_m.send(8, -1, 0);
        e = '{8'h01, 8'h10, 8'h00, 8'h30, 8'h00, 8'h02};
        expect_rsp();
        chk("wr_cnt", 16'(w_cnt), 16'h0002);
        chk("wr_last", w_adr, 16'h0031);
        chk("wr_ldat", w_dat, 16'h0022);
    endtask
    task automatic t_errs;
        logic [47:0] tb [6];
        logic [15:0] ex [6];
        tb = '{48'h0105_0000_0001, 48'h0103_2000_0001, 48'h0103_0000_007e,
               48'h0106_0005_0001, 48'h0106_0040_1000, 48'h0108_0001_0000};
        ex = '{16'h8501, 16'h8302, 16'h8303, 16'h8602, 16'h8603, 16'h8803};
        w_cnt = 0;
        foreach (tb[i]) begin
            u_m.q = {};
            for (int j = 5; j >= 0; j--)
                u_m.q.push_back(tb[i][j*8+:8]);
            u_m.send(8, -1, 0);
            e = '{8'h01, ex[i][15:8], ex[i][7:0]};
            expect_rsp();
        end
        chk("err_no_wr", 16'(w_cnt), 16'h0000);
    endtask
    task automatic t_silent;
        sadr = 5'h00;
        repeat (3) @(posedge clk);
        ld_read();
        u_m.send(8, -1, 0);
        expect_none();
        sadr = 5'h01;
        repeat (3) @(posedge clk);
        ld_read();
        u_m.send(8, 3, 0);
        expect_none();
        ld_read();
        u_m.send(8, -1, 1);
        expect_none();
        ld_read();
        u_m.send(GAP + 4, -1, 0);
        expect_none();
    endtask
    task automatic t_fault;
        fault = 1'b1;
        repeat (4) @(posedge clk);
        ld_read();
        u_m.send(8, -1, 0);
        e = '{8'h01, 8'h83, 8'h03};
        expect_rsp();
        fault = 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic t_mode2;
        mode2 = 1'b1;
        repeat (4) @(posedge clk);
        ld_read();
        u_m.send(GAP + 8, -1, 0);
        expect_rsp();
        mode2 = 1'b0;
        repeat (4) @(posedge clk);
    endtask
    //************
    // Run control
    //************
    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        rstn = 1'b0;
        fault = 1'b0;
        mode2 = 1'b0;
        sadr = 5'h01;
        repeat (2) @(posedge clk);
        #1;
        rstn = 1'b1;
        repeat (3) @(posedge clk);
        t_read();
        t_echo();
        t_multi();
        t_errs();
        t_silent();
        t_fault();
        t_mode2();
        stop_test();
    end
    // About eight times the expected run length.
    initial begin
        #5000000;
        err_count++;
        stop_test();
    end
endmodule

// >>> verilog/mbrs_crc16.v
// Running 16-bit check code over a byte stream.
`timescale 1ns/100ps
`include "mbrs_map.vh"

module mbrs_crc16 (
    input wire i_sys_clk,
    input wire i_rstn,
    input wire i_ce,
    input wire i_clr,
    input wire i_en,
    input wire [7:0] i_data,
    output wire [15:0] o_crc
);

    reg [15:0] crc_ff;

    function [15:0] crc_step;
        input [15:0] c;
        input [7:0] d;
        reg [15:0] r;
        integer n;
        begin
            r = c ^ {8'h00, d};
            for (n = 0; n < 8; n = n + 1) begin
                if (r[0]) begin
                    r = (r >> 1) ^ `MBRS_CRC_POLY; // (R17)
                end else begin
                    r = r >> 1;
                end
            end
            crc_step = r;
        end
    endfunction

    always @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            crc_ff <= `MBRS_CRC_INIT; // (R16)
        end else if (i_ce) begin
            if (i_clr) begin
                crc_ff <= `MBRS_CRC_INIT; // (R16)
            end else if (i_en) begin
                crc_ff <= crc_step(crc_ff, i_data); // (R17)
            end
        end
    end

    assign o_crc = crc_ff;

endmodule

// >>> verilog/mbrs_gap_timer.v
// Inter-character gap timer measured in bit times.
`timescale 1ns/100ps
`include "mbrs_map.vh"

module mbrs_gap_timer #(
    parameter integer P_EXT_CYC = `MBRS_EXT_CYC
) (
    input wire i_sys_clk,
    input wire i_rstn,
    input wire i_ce,
    input wire i_restart,
    input wire i_mode2,
    input wire [15:0] i_bit_div,
    output wire o_gap
);

    reg [15:0] div_cnt_ff;
    reg [4:0] bit_cnt_ff;
    reg [31:0] ext_cnt_ff;
    reg armed_ff;
    reg gap_ff;

    // The timer fires once per silence; only a new character re-arms it.
    always @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            div_cnt_ff <= 16'h0000;
            bit_cnt_ff <= 5'h00;
            ext_cnt_ff <= 32'h0000_0000;
            armed_ff <= 1'b0;
            gap_ff <= 1'b0;
        end else if (i_ce) begin
            gap_ff <= 1'b0;
            if (i_restart) begin
                div_cnt_ff <= 16'h0000; // (R23)
                bit_cnt_ff <= 5'h00;
                ext_cnt_ff <= 32'h0000_0000;
                armed_ff <= 1'b1;
            end else if (armed_ff) begin
                if (bit_cnt_ff < `MBRS_GAP_BITS) begin
                    if (div_cnt_ff + 16'h0001 >= i_bit_div) begin
                        div_cnt_ff <= 16'h0000;
                        bit_cnt_ff <= bit_cnt_ff + 5'h01; // (R23)
                    end else begin
                        div_cnt_ff <= div_cnt_ff + 16'h0001;
                    end
                end else if (i_mode2 && (ext_cnt_ff + 32'h1 < P_EXT_CYC)) begin
                    ext_cnt_ff <= ext_cnt_ff + 32'h0000_0001; // (R23)
                end else begin
                    gap_ff <= 1'b1; // (R5)
                    armed_ff <= 1'b0;
                end
            end
        end
    end

    assign o_gap = gap_ff;

endmodule

// >>> verilog/mbrs_handler.v
// Serial-line slave query handler: framing, checks, register access, replies.
`timescale 1ns/100ps
`include "mbrs_map.vh"

//**************
// Summary of operation
// (R1) Only functions 03H, 06H, 08H, 10H; else code 1.
// (R2) Query and response lengths fixed per function.
// (R3) Binary bytes, frames delimited only by idle gaps.
// (R4) Master keeps character gaps below the limit.
// (R5) Gap at limit ends query; malformed ones ignored.
// (R6) Read reply: address, function, count, register data.
// (R7) Preset single and loopback echo the query.
// (R8) Multiple preset reply: address, function, start, quantity.
// (R9) Defective query gets error reply, no register action.
// (R10) Self-diagnosed fault makes every reply an error.
// (R11) Error reply: function plus 80H, one-byte code.
// (R12) Code 2: read-only write or address above 1FFFH.
// (R13) Code 3: data out of range or count too large.
// (R14) Silent when address differs from own address.
// (R15) Character reception errors make the query ignored.
// (R16) Check code starts at FFFFH, data bytes only.
// (R17) XOR byte, eight right shifts, A001 on carry.
// (R18) Check code appended low byte then high byte.
// (R19) Check code mismatch discards query silently.
// (R20) Own address 1 to 16 from front switch.
// (R21) Master sets loopback test code to zero.
// (R22) Replies carry check code, low byte first.
// (R23) Gap timer counts bit times, 2 ms extension mode two.
//**************

module mbrs_handler #(
    parameter integer P_EXT_CYC = `MBRS_EXT_CYC
) (
    input wire i_sys_clk,
    input wire i_rstn,
    input wire i_ce,
    input wire i_rx_valid,
    input wire [7:0] i_rx_data,
    input wire i_rx_err,
    input wire [4:0] i_slave_addr,
    input wire i_diag_fault,
    input wire i_gap_mode2,
    input wire [15:0] i_bit_div,
    output wire o_tx_valid,
    output wire [7:0] o_tx_data,
    input wire i_tx_ready,
    output wire [15:0] o_reg_addr,
    output wire [15:0] o_reg_wdata,
    output wire o_reg_wr,
    input wire [15:0] i_reg_rdata,
    input wire i_reg_writable,
    input wire i_reg_in_range
);

    localparam [4:0] ST_RX = 5'h01;
    localparam [4:0] ST_EVAL = 5'h02;
    localparam [4:0] ST_CHK = 5'h04;
    localparam [4:0] ST_WR = 5'h08;
    localparam [4:0] ST_TX = 5'h10;

    //************
    // Pin synchronisers
    //************
    reg [4:0] addr_s1_ff;
    reg [4:0] addr_s2_ff;
    reg fault_s1_ff;
    reg fault_s2_ff;
    reg mode_s1_ff;
    reg mode_s2_ff;

    always @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            addr_s1_ff <= 5'h00;
            addr_s2_ff <= 5'h00;
            fault_s1_ff <= 1'b0;
            fault_s2_ff <= 1'b0;
            mode_s1_ff <= 1'b0;
            mode_s2_ff <= 1'b0;
        end else if (i_ce) begin
            addr_s1_ff <= i_slave_addr;
            addr_s2_ff <= addr_s1_ff;
            fault_s1_ff <= i_diag_fault;
            fault_s2_ff <= fault_s1_ff;
            mode_s1_ff <= i_gap_mode2;
            mode_s2_ff <= mode_s1_ff;
        end
    end

    //************
    // State and query buffer
    //************
    reg [4:0] state_ff;
    reg [7:0] cnt_ff;
    reg bad_ff;
    reg err_ff;
    reg [7:0] ec_ff;
    reg [7:0] idx_ff;
    reg ph_ff;
    reg [7:0] tcnt_ff;
    reg tx_valid_ff;
    reg [7:0] tx_data_ff;
    reg [15:0] reg_addr_ff;
    reg [15:0] reg_wdata_ff;
    reg reg_wr_ff;
    reg [7:0] qbuf_mem [0:208];

    wire gap;
    wire [15:0] rx_crc;
    wire [15:0] tx_crc;
    wire rx_take = i_rx_valid && state_ff == ST_RX;
    wire tx_take = tx_valid_ff && i_tx_ready;

    // Storing stops at the longest legal query; excess only marks it bad.
    always @(posedge i_sys_clk) begin
        if (i_ce && rx_take && cnt_ff < `MBRS_QLEN_MAX) begin
            qbuf_mem[cnt_ff] <= i_rx_data; // (R3)
        end
    end

    //************
    // Query field decode
    //************
    wire [7:0] fn = qbuf_mem[1];
    wire [15:0] start = {qbuf_mem[2], qbuf_mem[3]};
    wire [15:0] qty = {qbuf_mem[4], qbuf_mem[5]};
    wire [7:0] bcnt = qbuf_mem[6];
    wire is_rd = fn == `MBRS_FN_READ;
    wire is_ps = fn == `MBRS_FN_PRESET;
    wire is_lb = fn == `MBRS_FN_LOOP;
    wire is_mw = fn == `MBRS_FN_MULTI;
    wire fn_known = is_rd || is_ps || is_lb || is_mw; // (R1)
    wire [16:0] last_reg = {1'b0, start} + {1'b0, qty} - 17'h00001;
    wire [15:0] wr_qty = is_ps ? 16'h0001 : qty;
    wire last_idx = {8'h00, idx_ff} == wr_qty - 16'h0001;
    wire [7:0] dbase = is_mw ? `MBRS_MULTI_DBASE : `MBRS_SINGLE_DBASE;
    wire [7:0] wr_ptr = dbase + {idx_ff[6:0], 1'b0};
    wire [15:0] wr_addr = start + {8'h00, idx_ff};
    wire [15:0] wr_data = {qbuf_mem[wr_ptr], qbuf_mem[wr_ptr + 8'h01]};
    wire [7:0] rd_off = tcnt_ff - `MBRS_RSP_RD_HDR;
    wire [15:0] rd_addr = start + {9'h000, rd_off[7:1]};

    wire addr_ok = addr_s2_ff >= `MBRS_ADDR_MIN &&
        addr_s2_ff <= `MBRS_ADDR_MAX &&
        qbuf_mem[0] == {3'h0, addr_s2_ff}; // (R20)

    // A correct check code run over the trailing code itself leaves zero.
    wire drop = bad_ff || cnt_ff < `MBRS_QLEN_MIN || // (R15)
        rx_crc != 16'h0000 || // (R19)
        !addr_ok; // (R14)

    wire len_ok = is_mw ?
        (cnt_ff >= `MBRS_QLEN_MIN_MULTI &&
         {1'b0, cnt_ff} == {1'b0, bcnt} + `MBRS_MULTI_OVH) :
        cnt_ff == `MBRS_QLEN_FIX; // (R2)

    reg qty_bad;
    reg range_bad;
    always @* begin
        qty_bad = 1'b0;
        range_bad = 1'b0;
        if (is_rd) begin
            qty_bad = qty == 16'h0000 || qty > `MBRS_RD_QTY_MAX; // (R13)
            range_bad = last_reg > `MBRS_REG_TOP; // (R12)
        end else if (is_mw) begin
            qty_bad = qty == 16'h0000 || qty > `MBRS_WR_QTY_MAX ||
                {qty[14:0], 1'b0} != {8'h00, bcnt}; // (R13)
            range_bad = last_reg > `MBRS_REG_TOP; // (R12)
        end else if (is_lb) begin
            qty_bad = start != 16'h0000; // (R21)
        end else begin
            range_bad = {1'b0, start} > `MBRS_REG_TOP; // (R12)
        end
    end

    //************
    // Reply byte selection
    //************
    wire [7:0] body_len = err_ff ? `MBRS_RSP_ERR_LEN :
        is_rd ? `MBRS_RSP_RD_HDR + {qty[6:0], 1'b0} :
        `MBRS_RSP_FIX_LEN;

    reg [7:0] tx_byte;
    always @* begin
        tx_byte = qbuf_mem[tcnt_ff]; // (R7) (R8)
        if (tcnt_ff == body_len) begin
            tx_byte = tx_crc[7:0]; // (R22)
        end else if (tcnt_ff > body_len) begin
            tx_byte = tx_crc[15:8]; // (R22)
        end else if (err_ff) begin
            if (tcnt_ff == 8'h01) begin
                tx_byte = fn | `MBRS_ERR_FLAG; // (R11)
            end else if (tcnt_ff == 8'h02) begin
                tx_byte = ec_ff; // (R11)
            end
        end else if (is_rd && tcnt_ff == 8'h02) begin
            tx_byte = {qty[6:0], 1'b0}; // (R6)
        end else if (is_rd && tcnt_ff > 8'h02) begin
            tx_byte = tcnt_ff[0] ? i_reg_rdata[15:8] :
                i_reg_rdata[7:0]; // (R6)
        end
    end

    //************
    // Main sequencer
    //************
    always @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            state_ff <= ST_RX;
            cnt_ff <= 8'h00;
            bad_ff <= 1'b0;
            err_ff <= 1'b0;
            ec_ff <= 8'h00;
            idx_ff <= 8'h00;
            ph_ff <= 1'b0;
            tcnt_ff <= 8'h00;
            tx_valid_ff <= 1'b0;
            tx_data_ff <= 8'h00;
            reg_addr_ff <= 16'h0000;
            reg_wdata_ff <= 16'h0000;
            reg_wr_ff <= 1'b0;
        end else if (i_ce) begin
            reg_wr_ff <= 1'b0;
            case (state_ff)
                ST_RX: begin
                    if (i_rx_valid) begin
                        if (cnt_ff < `MBRS_QLEN_MAX) begin
                            cnt_ff <= cnt_ff + 8'h01;
                        end else begin
                            bad_ff <= 1'b1; // (R2)
                        end
                        if (i_rx_err) begin
                            bad_ff <= 1'b1; // (R15)
                        end
                    end else if (gap) begin
                        if (cnt_ff == 8'h00) begin
                            bad_ff <= 1'b0;
                        end else begin
                            state_ff <= ST_EVAL; // (R5)
                        end
                    end
                end
                ST_EVAL: begin
                    bad_ff <= 1'b0;
                    cnt_ff <= 8'h00;
                    idx_ff <= 8'h00;
                    ph_ff <= 1'b0;
                    tcnt_ff <= 8'h00;
                    err_ff <= 1'b1;
                    state_ff <= ST_TX;
                    if (drop) begin
                        err_ff <= 1'b0;
                        state_ff <= ST_RX; // (R5) (R19)
                    end else if (fault_s2_ff) begin
                        ec_ff <= `MBRS_EC_FAULT; // (R10)
                    end else if (!fn_known) begin
                        ec_ff <= `MBRS_EC_FUNC; // (R1)
                    end else if (!len_ok || qty_bad) begin
                        ec_ff <= `MBRS_EC_DATA; // (R13)
                    end else if (range_bad) begin
                        ec_ff <= `MBRS_EC_ADDR; // (R12)
                    end else begin
                        err_ff <= 1'b0;
                        if (is_ps || is_mw) begin
                            state_ff <= ST_CHK; // (R9)
                        end
                    end
                end
                ST_CHK: begin
                    // Every target is vetted before any write is issued.
                    ph_ff <= ~ph_ff;
                    if (!ph_ff) begin
                        reg_addr_ff <= wr_addr;
                        reg_wdata_ff <= wr_data;
                    end else if (!i_reg_writable) begin
                        err_ff <= 1'b1;
                        ec_ff <= `MBRS_EC_ADDR; // (R12)
                        state_ff <= ST_TX; // (R9)
                    end else if (!i_reg_in_range) begin
                        err_ff <= 1'b1;
                        ec_ff <= `MBRS_EC_DATA; // (R13)
                        state_ff <= ST_TX; // (R9)
                    end else if (last_idx) begin
                        idx_ff <= 8'h00;
                        state_ff <= ST_WR;
                    end else begin
                        idx_ff <= idx_ff + 8'h01;
                    end
                end
                ST_WR: begin
                    ph_ff <= ~ph_ff;
                    if (!ph_ff) begin
                        reg_addr_ff <= wr_addr;
                        reg_wdata_ff <= wr_data;
                        reg_wr_ff <= 1'b1;
                    end else if (last_idx) begin
                        idx_ff <= 8'h00;
                        state_ff <= ST_TX;
                    end else begin
                        idx_ff <= idx_ff + 8'h01;
                    end
                end
                ST_TX: begin
                    if (!ph_ff) begin
                        reg_addr_ff <= rd_addr; // (R6)
                        ph_ff <= 1'b1;
                    end else if (!tx_valid_ff) begin
                        tx_data_ff <= tx_byte;
                        tx_valid_ff <= 1'b1;
                    end else if (i_tx_ready) begin
                        tx_valid_ff <= 1'b0;
                        ph_ff <= 1'b0;
                        tcnt_ff <= tcnt_ff + 8'h01;
                        if (tcnt_ff == body_len + 8'h01) begin
                            tcnt_ff <= 8'h00; // (R18)
                            err_ff <= 1'b0;
                            state_ff <= ST_RX;
                        end
                    end
                end
                default: begin
                    state_ff <= ST_RX;
                end
            endcase
            // Characters heard while busy spoil whatever frame they belong to.
            if (i_rx_valid && state_ff != ST_RX) begin
                bad_ff <= 1'b1;
            end
        end
    end

    //************
    // Check code units and gap timer
    //************
    mbrs_crc16 u_rx_crc (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .i_ce(i_ce),
        .i_clr(state_ff != ST_RX), // (R16)
        .i_en(rx_take),
        .i_data(i_rx_data),
        .o_crc(rx_crc)
    );

    mbrs_crc16 u_tx_crc (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .i_ce(i_ce),
        .i_clr(state_ff == ST_RX), // (R22)
        .i_en(state_ff == ST_TX && tx_take && tcnt_ff < body_len),
        .i_data(tx_data_ff),
        .o_crc(tx_crc)
    );

    mbrs_gap_timer #(
        .P_EXT_CYC(P_EXT_CYC)
    ) u_gap (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .i_ce(i_ce),
        .i_restart(i_rx_valid), // (R23)
        .i_mode2(mode_s2_ff),
        .i_bit_div(i_bit_div),
        .o_gap(gap)
    );

    assign o_tx_valid = tx_valid_ff;
    assign o_tx_data = tx_data_ff;
    assign o_reg_addr = reg_addr_ff;
    assign o_reg_wdata = reg_wdata_ff;
    assign o_reg_wr = reg_wr_ff;

endmodule

// >>> verilog/mbrs_map.vh
// Constants for the serial-line slave query handler.
`ifndef MBRS_MAP_VH
`define MBRS_MAP_VH

//**************
// Function codes and error codes
//**************
`define MBRS_FN_READ 8'h03
`define MBRS_FN_PRESET 8'h06
`define MBRS_FN_LOOP 8'h08
`define MBRS_FN_MULTI 8'h10
`define MBRS_ERR_FLAG 8'h80
`define MBRS_EC_FUNC 8'h01
`define MBRS_EC_ADDR 8'h02
`define MBRS_EC_DATA 8'h03
`define MBRS_EC_FAULT 8'h03

//**************
// Message layout and limits
//**************
`define MBRS_QLEN_FIX 8'h08
`define MBRS_QLEN_MIN_MULTI 8'h0b
`define MBRS_QLEN_MAX 8'hd1
`define MBRS_QLEN_MIN 8'h04
`define MBRS_MULTI_OVH 9'h009
`define MBRS_SINGLE_DBASE 8'h04
`define MBRS_MULTI_DBASE 8'h07
`define MBRS_RSP_ERR_LEN 8'h03
`define MBRS_RSP_FIX_LEN 8'h06
`define MBRS_RSP_RD_HDR 8'h03
`define MBRS_RD_QTY_MAX 16'h007d
`define MBRS_WR_QTY_MAX 16'h0064
`define MBRS_REG_TOP 17'h01fff
`define MBRS_ADDR_MIN 5'h01
`define MBRS_ADDR_MAX 5'h10

//**************
// Check code and timing
//**************
`define MBRS_CRC_INIT 16'hffff
`define MBRS_CRC_POLY 16'ha001
`define MBRS_GAP_BITS 5'h18
`define MBRS_CLK_MHZ 10
`define MBRS_EXT_US 2000
`define MBRS_EXT_CYC (`MBRS_EXT_US * `MBRS_CLK_MHZ)

`endif
